// ---- verilog/uft_pkg.sv ----
// constants, command codes and carrier types for the frame timing block
package uft_pkg;

    // host port command codes
    localparam logic [7:0]  CMD_RD_LEFT = 8'h0e;
    localparam logic [7:0]  CMD_WR_LEFT = 8'h8e;
    localparam logic [7:0]  CMD_RD_SEQ  = 8'h0f;
    localparam logic [7:0]  CMD_WR_SEQ  = 8'h8f;
    localparam logic [7:0]  CMD_RD_SLOW = 8'h11;
    localparam logic [7:0]  CMD_WR_SLOW = 8'h91;

    // field widths and positions
    localparam int          LEFT_W      = 14;
    localparam int          SEQ_W       = 16;
    localparam int          SLOW_W      = 11;
    localparam int          TOG_POS     = 31;

    // values after reset
    localparam logic [13:0] LEFT_RESET  = 14'h0000;
    localparam logic [15:0] SEQ_RESET   = 16'h0000;
    localparam logic [10:0] SLOW_RESET  = 11'h628;
    localparam logic [13:0] LEN_NOMINAL = 14'h2edf;   // 11999 bit times

    // one command on the host port
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [31:0] wdata;
    } uft_cmd_t;

    // one answer on the host port
    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] data;
    } uft_rsp_t;

    // per-frame start sequence
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SOF,
        SEQ_PUBLISH,
        SEQ_DONE
    } uft_seq_t;

    // frame timer state
    typedef struct packed {
        logic [13:0] len;
        logic        len_tog;
        logic [13:0] left;
        logic        left_tog;
        logic        reload;
    } uft_tmr_t;

endpackage : uft_pkg

// ---- verilog/uft_frame_timer.sv ----
// frame-remaining down counter with interval shadow and toggle
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timer
    import uft_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // timing
    input  wire logic        bit_tick,
    input  wire logic        run,
    // interval field as programmed
    input  wire logic        len_load,
    input  wire logic [13:0] len_value,
    input  wire logic        len_tog,
    // direct loads
    input  wire logic        ld_en,
    input  wire logic        ld_from_len,
    input  wire logic [13:0] ld_value,
    input  wire logic        ld_tog,
    // state out
    output logic      [13:0] left,
    output logic             left_tog,
    output logic             reload
);

    uft_tmr_t cur_q;
    uft_tmr_t nxt_d;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        nxt_d = cur_q;
        if (ce)
        begin
            nxt_d.reload = 1'b0;
            if (len_load)
            begin
                nxt_d.len     = len_value;
                nxt_d.len_tog = len_tog;
            end
            if (ld_en)
            begin
                nxt_d.left     = ld_from_len ? cur_q.len : ld_value;
                nxt_d.left_tog = ld_from_len ? cur_q.left_tog : ld_tog;
            end
            else if (run && bit_tick)
            begin
                if (cur_q.left == '0)
                begin
                    // reload at the bit time after zero
                    nxt_d.left     = cur_q.len;
                    nxt_d.left_tog = cur_q.len_tog;
                    nxt_d.reload   = 1'b1;
                end
                else
                begin
                    // one bit time off per tick
                    nxt_d.left = cur_q.left - 14'h0001;
                end
            end
        end
    end

    // reset brings the interval back to nominal
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur_q <= '{len: LEN_NOMINAL, len_tog: 1'b0, left: LEFT_RESET,
                       left_tog: 1'b0, reload: 1'b0};
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    assign left     = cur_q.left;
    assign left_tog = cur_q.left_tog;
    assign reload   = cur_q.reload;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence at_zero_s;
        ce && run && bit_tick && !ld_en && cur_q.left == '0;
    endsequence

    zero_reload_a : assert property (at_zero_s |=> left == $past(cur_q.len) && reload)
        else $error("counter did not reload the interval at zero");
    zero_toggle_a : assert property (at_zero_s |=> left_tog == $past(cur_q.len_tog))
        else $error("toggle not copied on reload");
    count_down_a : assert property (ce && run && bit_tick && !ld_en && cur_q.left != '0
        |=> left == $past(cur_q.left) - 14'h0001)
        else $error("counter did not step down by one");
    entry_load_a : assert property (ce && ld_en && ld_from_len |=> left == $past(cur_q.len))
        else $error("entry did not load the interval");

endmodule : uft_frame_timer
`default_nettype wire

// ---- verilog/uft_frame_timing.sv ----
// frame timing top: host command port, frame number and frame start sequence
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - keep a 14-bit counter of bit times left in the frame.
// - count down each bit time; at zero reload the interval next bit time.
// - at zero copy the interval toggle into bit 31 of the counter register.
// - entering operation reloads the counter from the interval field.
// - frame number steps up each time the counter reloads.
// - frame number wraps from ffff to zero.
// - entering operation steps the frame number up.
// - publish the frame number after sof, before the first descriptor fetch.
// - raise the frame start flag once the number is published.
// - low-speed start only when bits left are at least the threshold.
// - the threshold does not change while operating.
// - counter register read with code 0e, written with 8e.
// - frame number read with 0f; 8f is its write code. The code accepts 8f without error but ignores the write.
// - threshold read with 11, written with 91.
// - every access is one whole 32-bit word.
// - hub status writes are open while operating.
// - interval field is 14 bits, nominal 11999 after reset.
module uft_frame_timing
    import uft_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // bit timing and controller state
    input  wire logic        bit_tick,
    input  wire logic        running_state,
    // interval field from the frame length register
    input  wire logic        frame_length_load,
    input  wire logic [13:0] frame_length_value,
    input  wire logic        frame_length_toggle,
    // host command port
    input  wire uft_cmd_t    cmd,
    output uft_rsp_t         rsp,
    // start of frame packet
    output logic             sof_req,
    input  wire logic        sof_done,
    // shared area write of the frame number
    output logic             hcca_wr_req,
    output logic      [15:0] hcca_wr_data,
    input  wire logic        hcca_wr_ack,
    // frame start flag and descriptor fetch permission
    output logic             frame_begin_flag_set,
    output logic             ed_fetch_ok,
    // low-speed commit check
    input  wire logic        ls_req,
    output logic             ls_grant,
    output logic             ls_deny,
    // hub status write permission
    output logic             hub_wr_ok
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [15:0] seq_cnt;
        logic [10:0] slow_lim;
        uft_seq_t    phase;
        logic        run_prev;
        uft_rsp_t    rsp;
        logic        sof_req;
        logic        hcca_req;
        logic [15:0] hcca_data;
        logic        flag_set;
        logic        ed_ok;
        logic        ls_grant;
        logic        ls_deny;
        logic        hub_ok;
    } uft_top_t;

    uft_top_t    cur_q;
    uft_top_t    nxt_d;
    logic [13:0] left;
    logic        left_tog;
    logic        reload;
    logic        run_rise;
    logic        wr_left;

    // known command codes, shared by decode and checks
    function automatic logic cmd_known(input logic [7:0] code);
        cmd_known = code inside {CMD_RD_LEFT, CMD_WR_LEFT, CMD_RD_SEQ,
                                 CMD_WR_SEQ, CMD_RD_SLOW, CMD_WR_SLOW};
    endfunction : cmd_known

    assign run_rise = running_state && !cur_q.run_prev;
    // write code for the counter register
    assign wr_left  = cmd.valid && cmd.code == CMD_WR_LEFT;

    ////////////////////////////////////////////////////////////////////////////
    // frame timer
    uft_frame_timer u_timer (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .bit_tick    (bit_tick),
        .run         (running_state),
        .len_load    (frame_length_load),
        .len_value   (frame_length_value),
        .len_tog     (frame_length_toggle),
        .ld_en       (run_rise || wr_left),
        .ld_from_len (run_rise),
        .ld_value    (cmd.wdata[LEFT_W-1:0]),
        .ld_tog      (cmd.wdata[TOG_POS]),
        .left        (left),
        .left_tog    (left_tog),
        .reload      (reload)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        nxt_d = cur_q;
        if (ce)
        begin
            nxt_d.run_prev = running_state;
            nxt_d.hub_ok   = running_state;     // hub status writable when running
            nxt_d.rsp      = '0;
            nxt_d.flag_set = 1'b0;
            nxt_d.ls_grant = 1'b0;
            nxt_d.ls_deny  = 1'b0;

            // host command decode; no byte lanes, so every access is a word
            // whole 32-bit word per access
            if (cmd.valid)
            begin
                nxt_d.rsp.valid = 1'b1;
                nxt_d.rsp.err   = !cmd_known(cmd.code);
                unique case (cmd.code)
                    // counter read, toggle in bit 31, rest zero
                    CMD_RD_LEFT: nxt_d.rsp.data = {left_tog, 17'h00000, left};
                    // frame number read; its write code is taken and ignored
                    CMD_RD_SEQ:  nxt_d.rsp.data = {16'h0000, cur_q.seq_cnt};
                    CMD_RD_SLOW: nxt_d.rsp.data = {21'h000000, cur_q.slow_lim};
                    default:     nxt_d.rsp.data = 32'h00000000;
                endcase
                if (cmd.code == CMD_WR_SLOW && !running_state)
                begin
                    nxt_d.slow_lim = cmd.wdata[SLOW_W-1:0];
                end
            end

            // low-speed start needs enough bit times left
            if (ls_req)
            begin
                nxt_d.ls_grant = ({3'h0, cur_q.slow_lim} <= left);
                nxt_d.ls_deny  = ({3'h0, cur_q.slow_lim} > left);
            end

            // frame start sequence
            unique case (cur_q.phase)
                SEQ_IDLE:
                begin
                end
                SEQ_SOF:
                begin
                    if (sof_done)
                    begin
                        // publish only once the sof has gone out
                        nxt_d.sof_req   = 1'b0;
                        nxt_d.hcca_req  = 1'b1;
                        nxt_d.hcca_data = cur_q.seq_cnt;
                        nxt_d.phase     = SEQ_PUBLISH;
                    end
                end
                SEQ_PUBLISH:
                begin
                    if (hcca_wr_ack)
                    begin
                        // flag follows the shared area write
                        nxt_d.hcca_req = 1'b0;
                        nxt_d.flag_set = 1'b1;
                        nxt_d.ed_ok    = 1'b1;
                        nxt_d.phase    = SEQ_DONE;
                    end
                end
                SEQ_DONE:
                begin
                end
            endcase

            // each reload opens a new frame number
            if (reload || run_rise)
            begin
                // plain 16-bit add wraps to zero
                nxt_d.seq_cnt  = cur_q.seq_cnt + 16'h0001;
                nxt_d.ed_ok    = 1'b0;          // no fetch before publishing
                nxt_d.sof_req  = 1'b1;
                nxt_d.hcca_req = 1'b0;
                nxt_d.phase    = SEQ_SOF;
            end
            else if (!running_state)
            begin
                // leaving operation abandons a frame in progress
                nxt_d.ed_ok    = 1'b0;
                nxt_d.sof_req  = 1'b0;
                nxt_d.hcca_req = 1'b0;
                nxt_d.phase    = SEQ_IDLE;
            end
        end
    end

    // register the whole state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur_q <= '{seq_cnt: SEQ_RESET, slow_lim: SLOW_RESET, phase: SEQ_IDLE,
                       default: '0};
        end
        else
        begin
            cur_q <= nxt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register
    assign rsp                  = cur_q.rsp;
    assign sof_req              = cur_q.sof_req;
    assign hcca_wr_req          = cur_q.hcca_req;
    assign hcca_wr_data         = cur_q.hcca_data;
    assign frame_begin_flag_set = cur_q.flag_set;
    assign ed_fetch_ok          = cur_q.ed_ok;
    assign ls_grant             = cur_q.ls_grant;
    assign ls_deny              = cur_q.ls_deny;
    assign hub_wr_ok            = cur_q.hub_ok;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence new_frame_s;
        ce && (reload || run_rise);
    endsequence

    sequence published_s;
        ce && cur_q.phase == SEQ_PUBLISH && hcca_wr_ack;
    endsequence

    // frame number
    seq_step_a : assert property (new_frame_s
        |=> cur_q.seq_cnt == $past(cur_q.seq_cnt) + 16'h0001)
        else $error("frame number did not step on reload");
    seq_wrap_a : assert property (new_frame_s and cur_q.seq_cnt == 16'hffff
        |=> cur_q.seq_cnt == '0)
        else $error("frame number did not wrap to zero");
    entry_step_a : assert property (ce && run_rise |=> sof_req && cur_q.phase == SEQ_SOF)
        else $error("operational entry did not start a frame");
    seq_wr_ignored_a : assert property (ce && cmd.valid && cmd.code == CMD_WR_SEQ
        && !reload && !run_rise |=> cur_q.seq_cnt == $past(cur_q.seq_cnt))
        else $error("frame number write was not ignored");

    // the fetch stays shut from a new frame until its number is out
    fetch_block_a : assert property (new_frame_s
        |=> sof_req && !hcca_wr_req && !ed_fetch_ok)
        else $error("new frame left the fetch open");
    publish_order_a : assert property ($rose(hcca_wr_req)
        |-> $past(sof_done) && !ed_fetch_ok)
        else $error("frame number published out of order");
    flag_after_pub_a : assert property (published_s ##0 !reload && running_state
        |=> frame_begin_flag_set && ed_fetch_ok)
        else $error("start flag not raised after publishing");
    flag_pulse_a : assert property (ce && frame_begin_flag_set |=> !frame_begin_flag_set)
        else $error("start flag stood longer than one cycle");

    // low-speed commit and threshold
    ls_check_a : assert property (ce && ls_req
        |=> ls_grant == ($past(left) >= $past(cur_q.slow_lim)) && ls_deny != ls_grant)
        else $error("low-speed commit decision wrong");
    slow_fixed_a : assert property (running_state && cur_q.run_prev
        |=> $stable(cur_q.slow_lim))
        else $error("threshold changed while operating");
    slow_write_a : assert property (ce && cmd.valid && cmd.code == CMD_WR_SLOW
        && !running_state |=> cur_q.slow_lim == $past(cmd.wdata[10:0]))
        else $error("threshold write did not land");
    slow_read_a : assert property (ce && cmd.valid && cmd.code == CMD_RD_SLOW
        |=> rsp.data == {21'h000000, $past(cur_q.slow_lim)})
        else $error("threshold read answer wrong");

    // host port
    left_read_a : assert property (ce && cmd.valid && cmd.code == CMD_RD_LEFT
        |=> rsp.valid && !rsp.err && rsp.data[30:14] == '0)
        else $error("counter read answer wrong");
    left_write_a : assert property (ce && wr_left && !run_rise
        |=> left == $past(cmd.wdata[13:0]) && left_tog == $past(cmd.wdata[31]))
        else $error("counter write did not land");
    seq_read_a : assert property (ce && cmd.valid && cmd.code == CMD_RD_SEQ
        |=> rsp.data == {16'h0000, $past(cur_q.seq_cnt)})
        else $error("frame number read answer wrong");
    bad_code_a : assert property (ce && cmd.valid && !cmd_known(cmd.code)
        |=> rsp.valid && rsp.err)
        else $error("unknown code not flagged");
    hub_open_a : assert property (ce |=> hub_wr_ok == $past(running_state))
        else $error("hub write permission does not follow the state");

endmodule : uft_frame_timing
`default_nettype wire

// ---- verification/uft_far_model.sv ----
// far-side model: start-of-frame sender and shared memory write port
`timescale 1ns/1ps
`default_nettype none
module uft_far_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // answer pace, high waits three cycles
    input  wire logic slow,
    // requests from the frame logic
    input  wire logic sof_req,
    input  wire logic hcca_wr_req,
    // one-cycle answers
    output logic      sof_done,
    output logic      hcca_wr_ack
);
    logic [1:0] sof_cnt_q;
    logic [1:0] mem_cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // answers are single pulses; the slow pace shows that requests hold until answered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sof_cnt_q   <= 2'h0;
            mem_cnt_q   <= 2'h0;
            sof_done    <= 1'b0;
            hcca_wr_ack <= 1'b0;
        end
        else
        begin
            sof_done    <= sof_req && !sof_done && (!slow || sof_cnt_q == 2'h3);
            hcca_wr_ack <= hcca_wr_req && !hcca_wr_ack && (!slow || mem_cnt_q == 2'h3);
            sof_cnt_q   <= (sof_req && !sof_done) ? sof_cnt_q + 2'h1 : 2'h0;
            mem_cnt_q   <= (hcca_wr_req && !hcca_wr_ack) ? mem_cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule : uft_far_model
`default_nettype wire

// ---- verification/tb.sv ----
// testbench: host port reads and writes, frame sequence, low-speed check
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uft_pkg::*;

    logic        clk, rst, ce, bit_tick, running_state, slow;
    logic        frame_length_load, frame_length_toggle;
    logic [13:0] frame_length_value;
    uft_cmd_t    cmd;
    uft_rsp_t    rsp;
    logic        sof_req, sof_done, hcca_wr_req, hcca_wr_ack;
    logic [15:0] hcca_wr_data;
    logic        frame_begin_flag_set, ed_fetch_ok, ls_req, ls_grant, ls_deny, hub_wr_ok;
    int          error_cnt;
    int          comparisons;

    uft_frame_timing dut (.clk(clk), .rst(rst), .ce(ce), .bit_tick(bit_tick),
        .running_state(running_state), .frame_length_load(frame_length_load),
        .frame_length_value(frame_length_value), .frame_length_toggle(frame_length_toggle),
        .cmd(cmd), .rsp(rsp), .sof_req(sof_req), .sof_done(sof_done),
        .hcca_wr_req(hcca_wr_req), .hcca_wr_data(hcca_wr_data), .hcca_wr_ack(hcca_wr_ack),
        .frame_begin_flag_set(frame_begin_flag_set), .ed_fetch_ok(ed_fetch_ok),
        .ls_req(ls_req), .ls_grant(ls_grant), .ls_deny(ls_deny), .hub_wr_ok(hub_wr_ok));

    uft_far_model far (.clk(clk), .rst(rst), .slow(slow), .sof_req(sof_req),
        .hcca_wr_req(hcca_wr_req), .sof_done(sof_done), .hcca_wr_ack(hcca_wr_ack));

    ////////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            comparisons++;
            if (got !== exp)
            begin
                error_cnt++;
                $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask : check

    task automatic give_up(input string what);
        begin
            error_cnt++;
            $display("wrong value at %0t: timed out waiting for %s", $time, what);
            tally_and_finish();
        end
    endtask : give_up

    ////////////////////////////////////////////////////////////////////////////////
    // one host command; the answer stands right after the taking edge, one cycle after the command
    task automatic access(input logic [7:0] cd, input logic [31:0] wd, output uft_rsp_t r);
        begin
            @(posedge clk);
            cmd <= '{valid: 1'b1, code: cd, wdata: wd};
            @(posedge clk);
            cmd <= '0;
            #1;
            check({31'h0, rsp.valid}, 32'h1, "answer one cycle after command");
            r = rsp;
        end
    endtask : access

    task automatic rd(input logic [7:0] cd, input logic [31:0] exp);
        uft_rsp_t r;
        begin
            access(cd, 32'h0, r);
            check({31'h0, r.err}, 32'h0, "read error flag");
            check(r.data, exp, "read data");
        end
    endtask : rd

    task automatic wr(input logic [7:0] cd, input logic [31:0] wd);
        uft_rsp_t r;
        begin
            access(cd, wd, r);
            check({31'h0, r.err}, 32'h0, "write error flag");
        end
    endtask : wr

    // low-speed request, expect {grant, deny} one cycle later
    task automatic ls_chk(input logic [1:0] exp);
        begin
            @(posedge clk);
            ls_req <= 1'b1;
            @(posedge clk);
            ls_req <= 1'b0;
            #1;
            check({30'h0, ls_grant, ls_deny}, {30'h0, exp}, "low-speed answer");
        end
    endtask : ls_chk

    task automatic ticks(input int n);
        begin
            repeat (n)
            begin
                @(posedge clk);
                bit_tick <= 1'b1;
            end
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask : ticks

    task automatic load_len(input logic [13:0] v, input logic tog);
        begin
            @(posedge clk);
            frame_length_value  <= v;
            frame_length_toggle <= tog;
            frame_length_load   <= 1'b1;
            @(posedge clk);
            frame_length_load   <= 1'b0;
        end
    endtask : load_len

    // publish must precede the fetch permission, flag lasts one cycle
    task automatic frame_check(input logic [15:0] exp_fn);
        int n;
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (hcca_wr_req !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (hcca_wr_req !== 1'b1) give_up("number publish");
            check({16'h0, hcca_wr_data}, {16'h0, exp_fn}, "published number");
            check({31'h0, ed_fetch_ok}, 32'h0, "fetch before publish");
            n = 0;
            while (frame_begin_flag_set !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (frame_begin_flag_set !== 1'b1) give_up("frame start flag");
            check({31'h0, ed_fetch_ok}, 32'h1, "fetch with flag");
            @(posedge clk);
            #1;
            check({31'h0, frame_begin_flag_set}, 32'h0, "flag one cycle");
        end
    endtask : frame_check

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        uft_rsp_t r;
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        ce = 1'b1;
        bit_tick = 1'b0;
        running_state = 1'b0;
        slow = 1'b1;
        frame_length_load = 1'b0;
        frame_length_toggle = 1'b0;
        frame_length_value = 14'h0000;
        cmd = '0;
        ls_req = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CMD_RD_LEFT, 32'h0000_0000);
        rd(CMD_RD_SEQ, 32'h0000_0000);
        rd(CMD_RD_SLOW, 32'h0000_0628);
        check({31'h0, hub_wr_ok}, 32'h0, "hub writes closed when stopped");
        access(8'h12, 32'hffff_ffff, r);
        check({r.err, r.data[30:0]}, 32'h8000_0000, "unknown code");
        wr(CMD_WR_SEQ, 32'hffff_ffff);
        rd(CMD_RD_SEQ, 32'h0000_0000);
        wr(CMD_WR_SLOW, 32'hffff_f0a5);
        rd(CMD_RD_SLOW, 32'h0000_00a5);
        wr(CMD_WR_LEFT, 32'hffff_ffff);
        rd(CMD_RD_LEFT, 32'h8000_3fff);
        wr(CMD_WR_LEFT, 32'h0000_0010);
        // count 16 against thresholds 0xa5, 0x10 (equal) and 0x11
        ls_chk(2'b01);
        wr(CMD_WR_SLOW, 32'h0000_0010);
        ls_chk(2'b10);
        wr(CMD_WR_SLOW, 32'h0000_0011);
        ls_chk(2'b01);
        // new interval of 9 with the toggle flipped, then go operational
        load_len(14'h0009, 1'b1);
        running_state <= 1'b1;
        frame_check(16'h0001);
        check({31'h0, hub_wr_ok}, 32'h1, "hub writes open when running");
        rd(CMD_RD_LEFT, 32'h0000_0009);
        rd(CMD_RD_SEQ, 32'h0000_0001);
        wr(CMD_WR_SLOW, 32'h0000_0100);
        rd(CMD_RD_SLOW, 32'h0000_0011);
        // one full frame: nine ticks down to zero, the tenth reloads
        slow <= 1'b0;
        ticks(10);
        frame_check(16'h0002);
        rd(CMD_RD_LEFT, 32'h8000_0009);
        rd(CMD_RD_SEQ, 32'h0000_0002);
        // clock enable low freezes the counter although ticks arrive
        @(posedge clk);
        ce <= 1'b0;
        bit_tick <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        bit_tick <= 1'b0;
        rd(CMD_RD_LEFT, 32'h8000_0009);
        // interval zero makes every tick a frame, so the number laps fast
        load_len(14'h0000, 1'b0);
        wr(CMD_WR_LEFT, 32'h0000_0000);
        ticks(65533);
        rd(CMD_RD_SEQ, 32'h0000_ffff);
        ticks(1);
        rd(CMD_RD_SEQ, 32'h0000_0000);
        rd(CMD_RD_LEFT, 32'h0000_0000);
        // reset in mid-run; stop too, so the release edge opens no frame
        @(posedge clk);
        running_state <= 1'b0;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CMD_RD_LEFT, 32'h0000_0000);
        rd(CMD_RD_SLOW, 32'h0000_0628);
        check({31'h0, hub_wr_ok}, 32'h0, "hub writes closed after reset");
        running_state <= 1'b1;
        frame_check(16'h0001);
        rd(CMD_RD_LEFT, 32'h0000_2edf);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
